// File: include/ris_pkg.sv
// Constants and carrier types for the interrupt and stop control block.
package ris_pkg;

   localparam int          CLK_HZ         = 20_000_000;
   localparam int          CNT_W          = 24;
   localparam int          DIV_W          = 12;

   // Mirrored control register addresses.
   localparam logic [7:0]  CTRL_ADDR_LO   = 8'h0F;
   localparam logic [7:0]  CTRL_ADDR_HI   = 8'h1F;
   localparam logic [7:0]  CTRL_RESET     = 8'h00;
   localparam logic [7:0]  RDATA_NONE     = 8'h00;

   // Control register field positions.
   localparam int          BIT_UPD_EN     = 5;
   localparam int          BIT_CD_EN      = 4;
   localparam int          BIT_ALARM_EN   = 3;
   localparam int          BIT_EXT_EN     = 2;
   localparam int          BIT_STOP       = 0;

   localparam logic [1:0]  CD_SEL_FAST    = 2'h0;

   // Auto-release widths in their natural units, and cycle counts at CLK_HZ.
   localparam real         UPD_SEC_MS     = 500.0;
   localparam real         UPD_MIN_MS     = 15.6;
   localparam real         CD_FAST_US     = 122.0;
   localparam real         CD_SLOW_MS     = 7.813;
   localparam int          UPD_SEC_CYC    = int'($floor(UPD_SEC_MS * CLK_HZ / 1000.0));
   localparam int          UPD_MIN_CYC    = int'($floor(UPD_MIN_MS * CLK_HZ / 1000.0));
   localparam int          CD_FAST_CYC    = int'($floor(CD_FAST_US * CLK_HZ / 1000000.0));
   localparam int          CD_SLOW_CYC    = int'($floor(CD_SLOW_MS * CLK_HZ / 1000.0));

   typedef struct packed {
      logic update_irq_enable;
      logic countdown_irq_enable;
      logic alarm_irq_enable;
      logic ext_event_irq_enable;
      logic stop;
   } ris_ctrl_s;

   // One-cycle event strobes from the timekeeping logic on this clock.
   typedef struct packed {
      logic update;
      logic update_is_minute;
      logic countdown;
      logic alarm;
   } ris_evt_s;

   // Flag clear strobes from the flag register logic.
   typedef struct packed {
      logic update;
      logic alarm;
      logic ext_event;
   } ris_flag_clr_s;

endpackage

// File: src/ris_pulse_timer.sv
// Retriggerable one-shot that holds an interrupt request for a loaded width.
`timescale 1ns/10ps
module ris_pulse_timer
   import ris_pkg::*;
#(
   parameter int W = CNT_W
) (
   input  wire logic         clk,
   input  wire logic         reset,
   input  wire logic         ce,
   input  wire logic         start,
   input  wire logic         abort,
   input  wire logic [W-1:0] len,
   output logic              active_q
);

   logic [W-1:0] count_q;

   // Abort beats start so a disabled or stopped source never shows a pulse.
   always_ff @(posedge clk) begin
      if (reset) begin
         count_q  <= '0;
         active_q <= 1'b0;
      end else if (ce) begin
         if (abort) begin
            count_q  <= '0;
            active_q <= 1'b0;
         end else if (start) begin
            count_q  <= len;
            active_q <= 1'b1;
         end else if (active_q) begin
            if (count_q <= W'(1)) begin
               active_q <= 1'b0;
               count_q  <= '0;
            end else begin
               count_q <= count_q - W'(1);
            end
         end
      end
   end

endmodule

// File: src/ris_ctrl.sv
// Interrupt gating, pulse widths and divider stop control of the clock core.
`timescale 1ns/10ps
//
// How it works
// - Update enable low: update event sets no flag, no interrupt; clearing withdraws it.
// - Update enable high: event sets flag, pulls interrupt low 500 ms or 15.6 ms.
// - Countdown enable low: no countdown interrupt; clearing enable withdraws an active one.
// - Countdown enable high: interrupt low 122 us when select is 00, else 7.813 ms.
// - Alarm enable high: interrupt held until alarm flag cleared; low cancels it.
// - Stop bit resets to 0 and counting then runs normally.
// - Stop bit 1 clears divider stages 2 Hz to 4 kHz and halts the clock.
// - While stopped the hundredths register is held at 00.
// - While stopped countdown, update and alarm interrupts cannot occur.
// - While stopped external event detection and its interrupt keep working.
// - Control register answers identically at addresses 0Fh and 1Fh.
module ris_ctrl
   import ris_pkg::*;
#(
   parameter int UPD_SEC_CYCLES = UPD_SEC_CYC,
   parameter int UPD_MIN_CYCLES = UPD_MIN_CYC,
   parameter int CD_SLOW_CYCLES = CD_SLOW_CYC
) (
   input  wire logic                clk,
   input  wire logic                reset,
   input  wire logic                ce,
   input  wire logic [7:0]          reg_addr,
   input  wire logic                reg_wr,
   input  wire logic                reg_rd,
   input  wire logic [7:0]          reg_wdata,
   output logic [7:0]               reg_rdata,
   input  wire logic                osc_tick,
   input  wire ris_evt_s            evt,
   input  wire logic [1:0]          countdown_clock_select,
   input  wire ris_flag_clr_s       flag_clr,
   input  wire logic                ext_event_input,
   output logic                     int_n,
   output logic                     update_flag,
   output logic                     alarm_flag,
   output logic                     ext_event_flag,
   output logic [DIV_W-1:0]         divider_q,
   output logic                     second_tick,
   output logic                     hundredths_clear,
   output logic                     clock_halted
);

   ris_ctrl_s          ctrl_q;
   logic [2:0]         ext_sync_q;
   logic               ext_edge;
   logic               addr_hit;
   logic               upd_active;
   logic               cd_active;
   logic               upd_start;
   logic               cd_start;
   logic [CNT_W-1:0]   upd_len;
   logic [CNT_W-1:0]   cd_len;

   assign addr_hit = (reg_addr == CTRL_ADDR_LO) || (reg_addr == CTRL_ADDR_HI);

   // Control storage; bits 7:6 and 1 are not stored at all.
   always_ff @(posedge clk) begin
      if (reset) begin
         ctrl_q <= '0;
      end else if (ce && reg_wr && addr_hit) begin
         ctrl_q.update_irq_enable    <= reg_wdata[BIT_UPD_EN];
         ctrl_q.countdown_irq_enable <= reg_wdata[BIT_CD_EN];
         ctrl_q.alarm_irq_enable     <= reg_wdata[BIT_ALARM_EN];
         ctrl_q.ext_event_irq_enable <= reg_wdata[BIT_EXT_EN];
         ctrl_q.stop                 <= reg_wdata[BIT_STOP];
      end
   end

   // Reads are registered; other addresses answer zero.
   always_ff @(posedge clk) begin
      if (reset) begin
         reg_rdata <= RDATA_NONE;
      end else if (ce && reg_rd) begin
         reg_rdata <= RDATA_NONE;
         if (addr_hit) begin
            reg_rdata[BIT_UPD_EN]   <= ctrl_q.update_irq_enable;
            reg_rdata[BIT_CD_EN]    <= ctrl_q.countdown_irq_enable;
            reg_rdata[BIT_ALARM_EN] <= ctrl_q.alarm_irq_enable;
            reg_rdata[BIT_EXT_EN]   <= ctrl_q.ext_event_irq_enable;
            reg_rdata[BIT_STOP]     <= ctrl_q.stop;
         end
      end
   end

   // The event pin is asynchronous; only the second and third stages feed logic.
   always_ff @(posedge clk) begin
      if (reset) begin
         ext_sync_q <= '0;
      end else if (ce) begin
         ext_sync_q <= {ext_sync_q[1:0], ext_event_input};
      end
   end

   assign ext_edge = ext_sync_q[1] & ~ext_sync_q[2];

   // Sub-second divider; the carry out of the 2 Hz stage is the seconds tick.
   always_ff @(posedge clk) begin
      if (reset) begin
         divider_q   <= '0;
         second_tick <= 1'b0;
      end else if (ce) begin
         second_tick <= 1'b0;
         if (ctrl_q.stop) begin
            divider_q <= '0;
         end else if (osc_tick) begin
            divider_q   <= divider_q + DIV_W'(1);
            second_tick <= &divider_q;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         hundredths_clear <= 1'b0;
         clock_halted     <= 1'b0;
      end else if (ce) begin
         hundredths_clear <= ctrl_q.stop;
         clock_halted     <= ctrl_q.stop;
      end
   end

   // Flags: a set in the same cycle as its clear wins, so no event is lost.
   always_ff @(posedge clk) begin
      if (reset) begin
         update_flag    <= 1'b0;
         alarm_flag     <= 1'b0;
         ext_event_flag <= 1'b0;
      end else if (ce) begin
         if (upd_start) begin
            update_flag <= 1'b1;
         end else if (flag_clr.update) begin
            update_flag <= 1'b0;
         end
         if (evt.alarm && !ctrl_q.stop) begin
            alarm_flag <= 1'b1;
         end else if (flag_clr.alarm) begin
            alarm_flag <= 1'b0;
         end
         if (ext_edge) begin
            ext_event_flag <= 1'b1;
         end else if (flag_clr.ext_event) begin
            ext_event_flag <= 1'b0;
         end
      end
   end

   assign upd_start = evt.update && ctrl_q.update_irq_enable && !ctrl_q.stop;
   assign cd_start  = evt.countdown && ctrl_q.countdown_irq_enable && !ctrl_q.stop;
   assign upd_len   = evt.update_is_minute ? CNT_W'(UPD_MIN_CYCLES) : CNT_W'(UPD_SEC_CYCLES);
   assign cd_len    = (countdown_clock_select == CD_SEL_FAST) ? CNT_W'(CD_FAST_CYC)
                                                              : CNT_W'(CD_SLOW_CYCLES);

   ris_pulse_timer #(.W(CNT_W)) u_update_pulse (
      .clk      (clk),
      .reset    (reset),
      .ce       (ce),
      .start    (upd_start),
      .abort    (!ctrl_q.update_irq_enable || ctrl_q.stop),
      .len      (upd_len),
      .active_q (upd_active)
   );

   ris_pulse_timer #(.W(CNT_W)) u_countdown_pulse (
      .clk      (clk),
      .reset    (reset),
      .ce       (ce),
      .start    (cd_start),
      .abort    (!ctrl_q.countdown_irq_enable || ctrl_q.stop),
      .len      (cd_len),
      .active_q (cd_active)
   );

   // Interrupt output is registered, so it lags the source state by one cycle.
   always_ff @(posedge clk) begin
      if (reset) begin
         int_n <= 1'b1;
      end else if (ce) begin
         int_n <= ~(upd_active
                  | cd_active
                  | (alarm_flag && ctrl_q.alarm_irq_enable && !ctrl_q.stop)
                  | (ext_event_flag && ctrl_q.ext_event_irq_enable));
      end
   end

endmodule

// File: verif/ris_ctrl_props.sv
// Assertion checker for the interrupt and stop control block.
`timescale 1ns/10ps
module ris_ctrl_props
   import ris_pkg::*;
(
   input wire logic             clk,
   input wire logic             reset,
   input wire logic             ce,
   input wire logic [7:0]       reg_addr,
   input wire logic             reg_wr,
   input wire logic             reg_rd,
   input wire logic [7:0]       reg_wdata,
   input wire logic [7:0]       reg_rdata,
   input wire ris_evt_s         evt,
   input wire logic             int_n,
   input wire logic             update_flag,
   input wire logic             alarm_flag,
   input wire logic             ext_event_flag,
   input wire logic [DIV_W-1:0] divider_q,
   input wire logic             second_tick,
   input wire logic             hundredths_clear,
   input wire logic             clock_halted
);
   logic [7:0] ctl_q;
   logic       hit;
   assign hit = (reg_addr == CTRL_ADDR_LO) || (reg_addr == CTRL_ADDR_HI);
   // Shadow of the control byte, so gating can be judged from the ports alone.
   always_ff @(posedge clk) begin
      if (reset)
         ctl_q <= CTRL_RESET;
      else if (ce && reg_wr && hit)
         ctl_q <= reg_wdata & 8'h3D;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   rd_bits_zero_a: assert property (reg_rdata[7:6] == 2'h0 && !reg_rdata[1])
      else $error("reserved read bits set");
   rd_mirror_a: assert property ($past(ce && reg_rd) |-> reg_rdata == ($past(hit) ? $past(ctl_q) : RDATA_NONE))
      else $error("read data wrong");
   upd_off_a: assert property (evt.update && !ctl_q[BIT_UPD_EN] && !update_flag |=> !update_flag)
      else $error("update flag set while disabled");
   upd_on_a: assert property (ce && evt.update && ctl_q[BIT_UPD_EN] && !ctl_q[BIT_STOP] |-> ##2 !int_n)
      else $error("update interrupt missing");
   halt_div_a: assert property (clock_halted && $past(clock_halted) |-> divider_q == '0 && hundredths_clear)
      else $error("divider not held while stopped");
   alarm_hold_a: assert property ((alarm_flag && ctl_q[BIT_ALARM_EN] && !ctl_q[BIT_STOP])[*3] |-> !int_n)
      else $error("alarm interrupt released");
   ext_hold_a: assert property ((ext_event_flag && ctl_q[BIT_EXT_EN])[*3] |-> !int_n)
      else $error("event interrupt released");
   idle_high_a: assert property ((ctl_q[5:2] == 4'h0)[*3] |-> int_n)
      else $error("interrupt low with all sources off");
   // A frozen clock enable holds the tick, so only a tick made at a live edge is judged.
   sec_tick_a: assert property (second_tick && $past(ce) |-> divider_q == '0 && $past(&divider_q))
      else $error("seconds tick without divider wrap");
   stop_quiet_a: assert property ((ctl_q[BIT_STOP] && !ctl_q[BIT_EXT_EN])[*3] |-> int_n)
      else $error("interrupt while stopped");
   cover property (evt.update && ctl_q[BIT_UPD_EN]);
   cover property (second_tick);
   cover property (alarm_flag && !int_n);
   cover property (clock_halted && ext_event_flag);
endmodule

bind ris_ctrl ris_ctrl_props ris_ctrl_props_inst (.*);

// File: verif/ris_host.sv
// Host model that writes and reads the control register a byte at a time.
`timescale 1ns/10ps
module ris_host (
   input  wire logic       clk,
   input  wire logic [7:0] reg_rdata,
   output logic [7:0]      reg_addr,
   output logic            reg_wr,
   output logic            reg_rd,
   output logic [7:0]      reg_wdata
);
   initial begin
      reg_addr = 8'hA5;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_wdata = 8'h5A;
   end
   // Released lines are inverted so a stale value is never mistaken for a live one.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      reg_addr = a;
      reg_wdata = {2'h0, d[5:0]};
      reg_wr = 1'b1;
      @(negedge clk);
      reg_wr = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~reg_wdata;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge clk);
      reg_rd = 1'b0;
      reg_addr = ~a;
      d = reg_rdata;
   endtask
endmodule

// File: verif/test_ris_ctrl.sv
// Self-checking bench for the interrupt and stop control block.
`timescale 1ns/10ps
module test_ris_ctrl
   import ris_pkg::*;
;
   logic             clk = 1'b0, reset = 1'b1, osc_tick = 1'b0, ext_event_input = 1'b0, ce = 1'b1;
   logic [7:0]       reg_addr, reg_wdata, reg_rdata, rv, d0;
   logic             reg_wr, reg_rd, int_n, update_flag, alarm_flag, ext_event_flag;
   logic             second_tick, hundredths_clear, clock_halted;
   logic [DIV_W-1:0] divider_q, dv;
   logic [1:0]       countdown_clock_select = 2'h0;
   ris_evt_s         evt = '0;
   ris_flag_clr_s    flag_clr = '0;
   int               n_errors = 0, checked = 0, w;
   ris_ctrl #(.UPD_SEC_CYCLES(50), .UPD_MIN_CYCLES(20), .CD_SLOW_CYCLES(30)) ris_ctrl_inst (.*);
   ris_host ris_host_inst (.*);
   initial forever #25 clk = ~clk;
   always @(negedge clk) osc_tick <= ~osc_tick;
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Only the four enables and the stop bit are stored; everything else reads back as zero.
   function automatic logic [7:0] exp_ctrl(input logic [7:0] v);
      exp_ctrl               = '0;
      exp_ctrl[BIT_UPD_EN]   = v[BIT_UPD_EN];
      exp_ctrl[BIT_CD_EN]    = v[BIT_CD_EN];
      exp_ctrl[BIT_ALARM_EN] = v[BIT_ALARM_EN];
      exp_ctrl[BIT_EXT_EN]   = v[BIT_EXT_EN];
      exp_ctrl[BIT_STOP]     = v[BIT_STOP];
   endfunction
   task automatic give_verdict;
      if (n_errors == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic strobe(input logic [3:0] e, input logic [2:0] c);
      @(negedge clk);
      evt = e;
      flag_clr = c;
      @(negedge clk);
      evt = '0;
      flag_clr = '0;
   endtask
   // Low time of int_n in cycles; a missing or endless pulse ends the run.
   task automatic width(input int exp);
      w = 0;
      for (int i = 0; i < 8 && int_n !== 1'b0; i++)
         @(negedge clk);
      while (int_n === 1'b0 && w < 3000) begin
         @(negedge clk);
         w++;
      end
      if (w == 0 || w >= 3000) begin
         check(0, 1);
         give_verdict();
      end
      check(w >= exp - 1 && w <= exp + 1, 1);
   endtask
   initial begin
      void'($urandom(73));
      repeat (20) @(negedge clk);
      reset = 1'b0;
      repeat (40) @(negedge clk);
      ris_host_inst.rd(CTRL_ADDR_LO, d0);
      check(d0, CTRL_RESET);
      check(divider_q != 0 && !clock_halted, 1);
      // With the clock enable low the divider must not move although the base tick runs.
      dv = divider_q;
      ce = 1'b0;
      repeat (5) @(negedge clk);
      check(divider_q, dv);
      ce = 1'b1;
      for (int i = 0; i < 5; i++) begin
         rv = (i == 0) ? 8'hFF : 8'($urandom);
         ris_host_inst.wr(i[0] ? CTRL_ADDR_HI : CTRL_ADDR_LO, rv);
         ris_host_inst.rd(CTRL_ADDR_LO, d0);
         check(d0, exp_ctrl(rv));
         ris_host_inst.rd(CTRL_ADDR_HI, d0);
         check(d0, exp_ctrl(rv));
      end
      ris_host_inst.rd(8'h2C, d0);
      check(d0, RDATA_NONE);
      ris_host_inst.wr(CTRL_ADDR_LO, 8'h20);
      for (int i = 0; i < 2; i++) begin
         strobe(4'h0, 3'h4);
         strobe({1'b1, i[0], 2'h0}, 3'h0);
         check(update_flag, 1'b1);
         width(i[0] ? 20 : 50);
      end
      ris_host_inst.wr(CTRL_ADDR_HI, 8'h10);
      for (int s = 0; s < 4; s++) begin
         countdown_clock_select = s[1:0];
         strobe(4'h2, 3'h0);
         width(s == 0 ? CD_FAST_CYC : 30);
      end
      ris_host_inst.wr(CTRL_ADDR_LO, 8'h00);
      strobe(4'h0, 3'h4);
      strobe(4'hA, 3'h0);
      repeat (4) @(negedge clk);
      check({int_n, update_flag}, 2'h2);
      ris_host_inst.wr(CTRL_ADDR_LO, 8'h08);
      strobe(4'h1, 3'h0);
      repeat (6) @(negedge clk);
      check({int_n, alarm_flag}, 2'h1);
      strobe(4'h0, 3'h2);
      repeat (4) @(negedge clk);
      check(int_n, 1'b1);
      // The divider wraps once per 4096 base ticks, 8192 cycles; a missing seconds tick ends the run.
      for (int i = 0; i < 9000 && second_tick !== 1'b1; i++)
         @(negedge clk);
      check(second_tick, 1'b1);
      if (second_tick !== 1'b1)
         give_verdict();
      ris_host_inst.wr(CTRL_ADDR_HI, 8'h25);
      repeat (3) @(negedge clk);
      check({divider_q == 0, hundredths_clear, clock_halted}, 3'h7);
      strobe(4'h8, 3'h0);
      repeat (4) @(negedge clk);
      check(int_n, 1'b1);
      ext_event_input = 1'b1;
      repeat (8) @(negedge clk);
      check({int_n, ext_event_flag}, 2'h1);
      give_verdict();
   end
endmodule
